// *** logic/crs_params.svh ***
// register indices, field positions and reset values of the crc engine and scanner
`ifndef CRS_PARAMS_SVH
`define CRS_PARAMS_SVH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define CRS_IDX_DATA 14'h034e
`define CRS_IDX_OVL 14'h0352
`define CRS_IDX_CTL 14'h0356
`define CRS_IDX_POLY_LENGTH_MINUS_ONE 14'h0357
`define CRS_IDX_WORD_LENGTH_MINUS_ONE 14'h0358
`define CRS_IDX_SCAN 14'h0360
`define CRS_IDX_SCAN_CURRENT_ADDRESS 14'h0362
`define CRS_IDX_SCAN_END_ADDRESS 14'h0363

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define CRS_CTL_EN 7
`define CRS_CTL_GO 6
`define CRS_CTL_BUSY 5
`define CRS_CTL_SETUP_HI 4
`define CRS_CTL_SETUP_LO 3
`define CRS_CTL_SHIFTM 1
`define CRS_CTL_FULL 0
`define CRS_SCAN_EN 7
`define CRS_SCAN_TRIG 6
`define CRS_SCAN_GO 5
`define CRS_SCAN_REGION 2
`define CRS_SCAN_BURST 1
`define CRS_SCAN_BUSY 0

// ----------------------------------------------------------------------
// overlay selections, reset values, bus answers
// ----------------------------------------------------------------------
`define CRS_OVL_SHIFT 2'h1
`define CRS_OVL_TAPS 2'h2
`define CRS_RST_REGION 1'h1
`define CRS_RST_ENDADDR 22'h3fffff
`define CRS_RESP_OKAY 2'h0
`define CRS_RESP_SLVERR 2'h2
`define CRS_FIFO_DEPTH 4

`endif

// *** logic/crs_pkg.sv ***
// types shared by the crc engine and scanner
package crs_pkg;

  // ----------------------------------------------------------------------
  // scanner sequence
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {SC_IDLE, SC_REQ, SC_PUSH} crs_scan_t;

  // ----------------------------------------------------------------------
  // whole state of the top module apart from its fifo
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic awHeld;
    logic [13:0] awIdx;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic [31:0] dataIn;
    logic dataFull;
    logic [31:0] result;
    logic [31:0] shifter;
    logic [31:0] taps;
    logic [4:0] bitCnt;
    logic shActive;
    logic crcEn;
    logic crc_go_a;
    logic [1:0] setup;
    logic shiftRight;
    logic [4:0] polyLen;
    logic [4:0] wordLen;
    logic scanEn;
    logic scanTrig;
    logic scanGo;
    logic scanRegion;
    logic scanBurst;
    logic [21:0] curAddr;
    logic [21:0] endAddr;
    crs_scan_t scanSt;
    logic [31:0] fetched;
    logic trigS1;
    logic trigS2;
  } crs_state_t;

endpackage

// *** logic/crs_fifo.sv ***
// small word fifo between the memory scanner and the crc engine
`timescale 1ns/1ps
module crs_fifo #(
  parameter int W = 32,
  parameter int D = 4
) (
  input wire logic clk_sys, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic inValid, // word offered
  input wire logic [W-1:0] inData, // word to store
  output logic inReady, // room for a word
  output logic outValid, // head word present
  output logic [W-1:0] outData, // head word, from storage flops
  input wire logic outReady // head word taken
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW:0] cnt;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
  } crs_fifo_st_t;

  crs_fifo_st_t st_ff;
  crs_fifo_st_t nxt_st;
  logic doPush;
  logic doPop;

  // honest flags: full and empty come straight from the count
  assign inReady = st_ff.cnt != (AW+1)'(D);
  assign outValid = st_ff.cnt != '0;
  assign outData = st_ff.mem[st_ff.rp];
  assign doPush = inValid && inReady;
  assign doPop = outValid && outReady;

  // pointer wrap written out so a depth that is not a power of two still works
  always_comb begin
    nxt_st = st_ff;
    if (doPush) begin
      nxt_st.mem[st_ff.wp] = inData;
      nxt_st.wp = (st_ff.wp == AW'(D-1)) ? '0 : st_ff.wp + 1'b1;
    end
    if (doPop) begin
      nxt_st.rp = (st_ff.rp == AW'(D-1)) ? '0 : st_ff.rp + 1'b1;
    end
    nxt_st.cnt = st_ff.cnt + (AW+1)'(doPush) - (AW+1)'(doPop);
  end

  // state register
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule // crs_fifo

// *** logic/crs_crc_scanner.sv ***
// crc engine with memory scanner, registers on an axi4-lite slave
// How it works
// - the word length field holds the bits per data word minus one.
// - the 32-bit data input register is read/write in four bytes and resets to zero.
// - writing the top byte of the result loads its top byte, reading returns it.
// - writing the low byte of the result loads its low byte, reading returns it.
// - the shifter is visible read-only, resets to zero, top byte reads its top byte.
// - result, shifter and tap mask share one address, chosen by the overlay setting.
// - the tap mask is read/write, resets to zero, each set bit adds a feedback term.
// - scanner control bit seven enables the scanner and resets to zero.
// - scanner control bit six gates fetches with the synchronised trigger input, except in burst mode.
// - while go is set the scanner fetches whenever the engine can take a word.
// - while go is clear there are no fetches; go resets to zero.
// - bit two picks data eeprom when one, program flash when zero, reset one.
// - overlay 01 reaches the shifter, 10 the tap mask, 00 and 11 the result.
// - the polynomial length field is length minus one and limits the feedback bits.
// - hardware clears go past the end address when idle, or when crc go is low.
// - burst mode keeps the memory request high; otherwise it follows room and trigger.
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`include "crs_params.svh"
module crs_crc_scanner (
  input wire logic clk_sys, // system clock, 10 MHz
  input wire logic nrst, // async reset, active low
  input wire logic [15:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [15:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic scanTrigIn, // selected trigger, asynchronous
  output logic memReq, // memory request to arbiter
  output logic [21:0] memAddr, // scan address
  output logic memRegion, // 1 data eeprom, 0 program flash
  input wire logic memAck, // one-cycle grant with data
  input wire logic [31:0] memData, // fetched word
  output logic crcBusy // shifting or data pending
);

  crs_pkg::crs_state_t s_ff;
  crs_pkg::crs_state_t nxt_s;
  logic fifoInReady;
  logic fifoOutValid;
  logic [31:0] fifoOut;
  logic fifoOutReady;
  logic loadSlot;
  logic doWrite;
  logic trigOk;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------

  // byte-lane merge for the data, overlay and address words; control and length registers take byte 0 only
  function automatic logic [31:0] wMerge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ones in bits 0..len
  function automatic logic [31:0] lenMask(input logic [4:0] len);
    return 32'hffffffff >> (5'h1f - len);
  endfunction

  function automatic logic isMapped(input logic [13:0] idx);
    return idx == `CRS_IDX_DATA || idx == `CRS_IDX_OVL || idx == `CRS_IDX_CTL || idx == `CRS_IDX_POLY_LENGTH_MINUS_ONE
      || idx == `CRS_IDX_WORD_LENGTH_MINUS_ONE || idx == `CRS_IDX_SCAN || idx == `CRS_IDX_SCAN_CURRENT_ADDRESS || idx == `CRS_IDX_SCAN_END_ADDRESS;
  endfunction

  // read mux; the overlay view is picked in the same cycle as the address
  function automatic logic [31:0] rdMux(input logic [13:0] idx, input crs_pkg::crs_state_t v);
    logic [31:0] r;
    r = 32'h0;
    case (idx)
      `CRS_IDX_DATA: r = v.dataIn;
      `CRS_IDX_OVL: begin
        case (v.setup)
          `CRS_OVL_SHIFT: r = v.shifter;
          `CRS_OVL_TAPS: r = v.taps;
          default: r = v.result;
        endcase
      end
      `CRS_IDX_CTL: begin
        r[`CRS_CTL_EN] = v.crcEn;
        r[`CRS_CTL_GO] = v.crc_go_a;
        r[`CRS_CTL_BUSY] = v.shActive || v.dataFull;
        r[`CRS_CTL_SETUP_HI:`CRS_CTL_SETUP_LO] = v.setup;
        r[`CRS_CTL_SHIFTM] = v.shiftRight;
        r[`CRS_CTL_FULL] = v.dataFull;
      end
      `CRS_IDX_POLY_LENGTH_MINUS_ONE: r[4:0] = v.polyLen;
      `CRS_IDX_WORD_LENGTH_MINUS_ONE: r[4:0] = v.wordLen;
      `CRS_IDX_SCAN: begin
        r[`CRS_SCAN_EN] = v.scanEn;
        r[`CRS_SCAN_TRIG] = v.scanTrig;
        r[`CRS_SCAN_GO] = v.scanGo;
        r[`CRS_SCAN_REGION] = v.scanRegion;
        r[`CRS_SCAN_BURST] = v.scanBurst;
        r[`CRS_SCAN_BUSY] = v.scanSt != crs_pkg::SC_IDLE;
      end
      `CRS_IDX_SCAN_CURRENT_ADDRESS: r[21:0] = v.curAddr;
      `CRS_IDX_SCAN_END_ADDRESS: r[21:0] = v.endAddr;
      default: r = 32'h0;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // port drives
  // ----------------------------------------------------------------------

  // a new write is held off until the previous answer is taken
  assign s_axi_awready = !s_ff.awHeld;
  assign s_axi_wready = !s_ff.wHeld;
  assign s_axi_bvalid = s_ff.bValid;
  assign s_axi_bresp = s_ff.bResp;
  assign s_axi_arready = !s_ff.rValid;
  assign s_axi_rvalid = s_ff.rValid;
  assign s_axi_rdata = s_ff.rData;
  assign s_axi_rresp = s_ff.rResp;
  assign memReq = s_ff.scanGo && s_ff.scanEn && (s_ff.scanBurst || s_ff.scanSt == crs_pkg::SC_REQ);
  assign memAddr = s_ff.curAddr;
  assign memRegion = s_ff.scanRegion;
  assign crcBusy = s_ff.shActive || s_ff.dataFull;
  assign doWrite = s_ff.awHeld && s_ff.wHeld && !s_ff.bValid;
  assign loadSlot = s_ff.crcEn && s_ff.crc_go_a && !s_ff.shActive;
  assign fifoOutReady = loadSlot && !s_ff.dataFull;
  assign trigOk = !s_ff.scanTrig || s_ff.trigS2;

  // fetched words queue here; its room is the scanner's view of crc readiness
  crs_fifo #(.W(32), .D(`CRS_FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .inValid(s_ff.scanSt == crs_pkg::SC_PUSH),
    .inData(s_ff.fetched),
    .inReady(fifoInReady),
    .outValid(fifoOutValid),
    .outData(fifoOut),
    .outReady(fifoOutReady)
  );

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic dBit;
    logic fb;
    dBit = 1'b0;
    fb = 1'b0;
    nxt_s = s_ff;
    // trigger synchroniser, second stage is the only reader of the first
    nxt_s.trigS1 = scanTrigIn;
    nxt_s.trigS2 = s_ff.trigS1;

    // engine: load a word, register copy first, then the fifo
    if (loadSlot && (s_ff.dataFull || fifoOutValid)) begin
      nxt_s.shifter = s_ff.dataFull ? s_ff.dataIn : fifoOut;
      nxt_s.dataFull = 1'b0;
      nxt_s.bitCnt = s_ff.wordLen;
      nxt_s.shActive = 1'b1;
    end else if (s_ff.shActive && s_ff.crcEn && s_ff.crc_go_a) begin
      dBit = s_ff.shiftRight ? s_ff.shifter[0] : s_ff.shifter[s_ff.wordLen];
      if (s_ff.shiftRight) begin
        fb = dBit ^ s_ff.result[0];
        nxt_s.result = ((s_ff.result >> 1) ^ (fb ? s_ff.taps : 32'h0)) & lenMask(s_ff.polyLen);
        nxt_s.shifter = s_ff.shifter >> 1;
      end else begin
        fb = dBit ^ s_ff.result[s_ff.polyLen];
        nxt_s.result = ((s_ff.result << 1) ^ (fb ? s_ff.taps : 32'h0)) & lenMask(s_ff.polyLen);
        nxt_s.shifter = s_ff.shifter << 1;
      end
      nxt_s.bitCnt = s_ff.bitCnt - 5'h1;
      nxt_s.shActive = s_ff.bitCnt != 5'h0;
    end

    // scanner sequence
    case (s_ff.scanSt)
      crs_pkg::SC_IDLE: begin
        if (s_ff.scanGo && s_ff.scanEn && s_ff.crc_go_a && s_ff.curAddr <= s_ff.endAddr
            && (s_ff.scanBurst || (fifoInReady && trigOk))) begin
          nxt_s.scanSt = crs_pkg::SC_REQ;
        end
      end
      crs_pkg::SC_REQ: begin
        if (!s_ff.scanGo || !s_ff.scanEn) begin
          nxt_s.scanSt = crs_pkg::SC_IDLE;
        end else if (memAck) begin
          nxt_s.fetched = memData;
          nxt_s.curAddr = s_ff.curAddr + 22'h1;
          nxt_s.scanSt = crs_pkg::SC_PUSH;
        end
      end
      crs_pkg::SC_PUSH: begin
        if (fifoInReady) begin
          nxt_s.scanSt = crs_pkg::SC_IDLE;
        end
      end
      default: nxt_s.scanSt = crs_pkg::SC_IDLE;
    endcase
    // hardware clear of go, past the end only between data cycles, at once when crc go is low
    if ((s_ff.curAddr > s_ff.endAddr && s_ff.scanSt == crs_pkg::SC_IDLE) || !s_ff.crc_go_a) begin
      nxt_s.scanGo = 1'b0;
    end

    // bus write channels, taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_s.awHeld = 1'b1;
      nxt_s.awIdx = s_axi_awaddr[15:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_s.wHeld = 1'b1;
      nxt_s.wData = s_axi_wdata;
      nxt_s.wStrb = s_axi_wstrb;
    end
    if (s_ff.bValid && s_axi_bready) begin
      nxt_s.bValid = 1'b0;
    end
    // software writes come after hardware updates so a new value is never lost
    if (doWrite) begin
      nxt_s.awHeld = 1'b0;
      nxt_s.wHeld = 1'b0;
      nxt_s.bValid = 1'b1;
      nxt_s.bResp = isMapped(s_ff.awIdx) ? `CRS_RESP_OKAY : `CRS_RESP_SLVERR;
      case (s_ff.awIdx)
        `CRS_IDX_DATA: begin
          nxt_s.dataIn = wMerge(s_ff.dataIn, s_ff.wData, s_ff.wStrb);
          nxt_s.dataFull = nxt_s.dataFull || s_ff.wStrb != 4'h0;
        end
        `CRS_IDX_OVL: begin
          case (s_ff.setup)
            `CRS_OVL_SHIFT: nxt_s.shifter = nxt_s.shifter;
            `CRS_OVL_TAPS: nxt_s.taps = wMerge(s_ff.taps, s_ff.wData, s_ff.wStrb);
            default: nxt_s.result = wMerge(nxt_s.result, s_ff.wData, s_ff.wStrb);
          endcase
        end
        `CRS_IDX_CTL: begin
          if (s_ff.wStrb[0]) begin
            nxt_s.crcEn = s_ff.wData[`CRS_CTL_EN];
            nxt_s.crc_go_a = s_ff.wData[`CRS_CTL_GO];
            nxt_s.setup = s_ff.wData[`CRS_CTL_SETUP_HI:`CRS_CTL_SETUP_LO];
            nxt_s.shiftRight = s_ff.wData[`CRS_CTL_SHIFTM];
          end
        end
        `CRS_IDX_POLY_LENGTH_MINUS_ONE: begin
          if (s_ff.wStrb[0]) begin
            nxt_s.polyLen = s_ff.wData[4:0];
          end
        end
        `CRS_IDX_WORD_LENGTH_MINUS_ONE: begin
          if (s_ff.wStrb[0]) begin
            nxt_s.wordLen = s_ff.wData[4:0];
          end
        end
        `CRS_IDX_SCAN: begin
          if (s_ff.wStrb[0]) begin
            nxt_s.scanEn = s_ff.wData[`CRS_SCAN_EN];
            nxt_s.scanTrig = s_ff.wData[`CRS_SCAN_TRIG];
            nxt_s.scanGo = s_ff.wData[`CRS_SCAN_GO];
            nxt_s.scanRegion = s_ff.wData[`CRS_SCAN_REGION];
            nxt_s.scanBurst = s_ff.wData[`CRS_SCAN_BURST];
          end
        end
        // address words ignore bus writes while a scan runs
        `CRS_IDX_SCAN_CURRENT_ADDRESS: begin
          if (!s_ff.scanGo) begin
            nxt_s.curAddr = 22'(wMerge({10'h0, s_ff.curAddr}, s_ff.wData, s_ff.wStrb));
          end
        end
        `CRS_IDX_SCAN_END_ADDRESS: begin
          if (!s_ff.scanGo) begin
            nxt_s.endAddr = 22'(wMerge({10'h0, s_ff.endAddr}, s_ff.wData, s_ff.wStrb));
          end
        end
        default: nxt_s.bResp = `CRS_RESP_SLVERR;
      endcase
    end

    // bus read: a pure view, nothing in the engine moves because of it
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_s.rValid = 1'b1;
      nxt_s.rData = rdMux(s_axi_araddr[15:2], s_ff);
      nxt_s.rResp = isMapped(s_axi_araddr[15:2]) ? `CRS_RESP_OKAY : `CRS_RESP_SLVERR;
    end else if (s_ff.rValid && s_axi_rready) begin
      nxt_s.rValid = 1'b0;
    end
  end

  // state register, constants only under reset
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_ff <= '0;
      s_ff.scanRegion <= `CRS_RST_REGION;
      s_ff.endAddr <= `CRS_RST_ENDADDR;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence fetchTaken;
    s_ff.scanSt == crs_pkg::SC_REQ && s_ff.scanGo && s_ff.scanEn && memAck;
  endsequence
  sequence pushed;
    s_ff.scanSt == crs_pkg::SC_PUSH ##[1:8] (s_ff.scanSt == crs_pkg::SC_IDLE);
  endsequence

  fetch_to_fifo_a: assert property (fetchTaken |=> s_ff.fetched == $past(memData) ##0 pushed or !fifoInReady)
    else $error("fetched word not passed on");
  no_fetch_a: assert property (!s_ff.scanGo |-> !memReq ##1 s_ff.scanSt != crs_pkg::SC_REQ)
    else $error("fetch activity while scan go clear");
  go_clear_a: assert property (s_ff.scanGo && !s_ff.crc_go_a && !doWrite |=> !s_ff.scanGo)
    else $error("scan go not cleared with crc go low");
  burst_req_a: assert property (s_ff.scanGo && s_ff.scanEn && s_ff.scanBurst && s_ff.crc_go_a && !doWrite
    && s_ff.scanSt == crs_pkg::SC_IDLE && s_ff.curAddr <= s_ff.endAddr
    |=> s_ff.scanSt == crs_pkg::SC_REQ && memReq)
    else $error("burst request dropped");
  trig_gate_a: assert property (s_ff.scanSt == crs_pkg::SC_IDLE && s_ff.scanTrig && !s_ff.trigS2 && !s_ff.scanBurst
    |=> s_ff.scanSt == crs_pkg::SC_IDLE)
    else $error("fetch started without trigger");
  word_load_a: assert property (loadSlot && s_ff.dataFull |=> s_ff.shActive && s_ff.bitCnt == $past(s_ff.wordLen)
    && s_ff.shifter == $past(s_ff.dataIn))
    else $error("data word not loaded with its length");
  shift_ro_a: assert property (doWrite && s_ff.awIdx == `CRS_IDX_OVL && s_ff.setup == `CRS_OVL_SHIFT
    && !s_ff.shActive && !loadSlot |=> $stable(s_ff.result) && $stable(s_ff.taps))
    else $error("shifter view write changed a register");
  taps_wr_a: assert property (doWrite && s_ff.awIdx == `CRS_IDX_OVL && s_ff.setup == `CRS_OVL_TAPS
    && s_ff.wStrb == 4'hf |=> s_ff.taps == $past(s_ff.wData))
    else $error("tap mask write lost");
  read_view_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[15:2] == `CRS_IDX_OVL
    && s_ff.setup == 2'h0 |=> s_axi_rvalid && s_axi_rdata == $past(s_ff.result))
    else $error("result read wrong");
  wr_answer_a: assert property (doWrite |=> s_axi_bvalid ##0 !s_ff.awHeld)
    else $error("write answer missing");

endmodule // crs_crc_scanner

// *** sim/crs_mem_model.sv ***
// memory arbiter model serving flash and eeprom words to the scanner
`timescale 1ns/1ps
module crs_mem_model (
  input wire logic clk_sys, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic memReq, // scanner request
  input wire logic [21:0] memAddr, // scan address
  input wire logic memRegion, // 1 eeprom, 0 flash
  output logic memAck, // one-cycle grant
  output logic [31:0] memData // fetched word
);
  logic [2:0] gap_ff;
  // grant after an idle gap; the gap is longer after an odd address
  // the data bus shows a changing pattern outside a grant
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      memAck <= 1'b0;
      memData <= 32'h0;
      gap_ff <= 3'h0;
    end else if (memAck) begin
      memAck <= 1'b0;
      memData <= ~memData;
      gap_ff <= memAddr[0] ? 3'h4 : 3'h1;
    end else if (gap_ff != 3'h0) begin
      gap_ff <= gap_ff - 3'h1;
      memData <= ~memData;
    end else if (memReq) begin
      memAck <= 1'b1;
      memData <= {memRegion ? 8'hee : 8'h5a, 2'h0, memAddr};
    end else begin
      memData <= ~memData;
    end
  end
endmodule // crs_mem_model

// *** sim/crs_crc_scanner_test.sv ***
// self-checking bench for the crc engine with memory scanner
`timescale 1ns/1ps
module crs_crc_scanner_test;
  typedef struct packed {logic [15:0] a; logic [31:0] d; logic [3:0] s; logic [31:0] e; logic [1:0] r;} crs_row_t;
  logic clk_sys, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, scanTrigIn, memReq, memRegion, memAck, crcBusy;
  logic [15:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, memData, v, acc, dataQ;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [21:0] memAddr, addrQ;
  logic ackQ, expRegion;
  int nErrors, samplesChecked, nAck;
  crs_row_t rows [14];
  crs_crc_scanner dut_u (.*);
  crs_mem_model mem_u (.*);
  // ----------------------------------------------------------------------
  // clock, bus tasks, reference crc
  // ----------------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samplesChecked++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      nErrors++;
    end
  endtask
  // address and data are offered together and dropped as each is taken
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_sys);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    {v, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask
  // left shift, 32-bit word and polynomial, taps of the table below
  function automatic logic [31:0] crcf(input logic [31:0] c, input logic [31:0] d);
    for (int i = 31; i >= 0; i--) c = (c << 1) ^ ((d[i] ^ c[31]) ? 32'h04c11db7 : 32'h0);
    return c;
  endfunction
  // scan done by hardware, then engine idle for eight cycles
  task automatic settle(input logic [7:0] ctl);
    int k;
    k = 0;
    repeat (80) begin
      rd(16'h0d80);
      if (v[5] === 1'b0) break;
    end
    chk("scan go cleared", {24'h0, ctl}, v);
    repeat (600) begin
      @(posedge clk_sys);
      k = (crcBusy === 1'b0) ? k + 1 : 0;
      if (k == 8) break;
    end
    chk("engine idle", 8, k);
  endtask
  // accepted grants: address steps by one, word enters the reference crc
  always @(posedge clk_sys) begin
    if (ackQ && memAddr !== addrQ) begin
      chk("memAddr", {10'h0, addrQ + 22'h1}, {10'h0, memAddr});
      chk("memRegion", {31'h0, expRegion}, {31'h0, memRegion});
      nAck++;
      acc = crcf(acc, dataQ);
    end
    {ackQ, addrQ, dataQ} <= {memAck && memReq, memAddr, memData};
  end
  task automatic wrapUp;
    $display("checks %0d mismatches %0d", samplesChecked, nErrors);
    if (nErrors == 0 && samplesChecked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // watchdog well above the longest scan sequence
  initial begin
    repeat (30000) @(posedge clk_sys);
    nErrors++;
    wrapUp();
  end
  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, scanTrigIn} = 7'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 68'h0;
    {ackQ, addrQ, dataQ, expRegion, nAck} = 0;
    rows = '{'{16'h0d80, 0, 0, 32'h04, 0}, '{16'h0d48, 0, 0, 0, 0}, '{16'h0d38, 0, 0, 0, 0},
      '{16'h0d60, '1, 1, 32'h1f, 0}, '{16'h0d5c, '1, 1, 32'h1f, 0}, '{16'h0d48, 32'hab0000ff, 8, 32'hab000000, 0},
      '{16'h0d48, 32'hcd, 1, 32'hab0000cd, 0}, '{16'h0d58, 32'h10, 1, 32'h10, 0},
      '{16'h0d48, 32'h04c11db7, 4'hf, 32'h04c11db7, 0}, '{16'h0d58, 32'h08, 1, 32'h08, 0},
      '{16'h0d48, '1, 4'hf, 0, 0}, '{16'h0d58, 32'h18, 1, 32'h18, 0}, '{16'h0d48, 0, 0, 32'hab0000cd, 0},
      '{16'h0010, 1, 4'hf, 0, 2}};
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].s != 4'h0) wr(rows[i].a, rows[i].d, rows[i].s);
      if (rows[i].s != 4'h0) chk("bresp", {30'h0, rows[i].r}, {30'h0, r});
      rd(rows[i].a);
      chk("read value", rows[i].e, v);
      chk("rresp", {30'h0, rows[i].r}, {30'h0, r});
    end
    $display("register table done");
    acc = crcf(32'hab0000cd, 32'h12345678);
    wr(16'h0d58, 32'hc0, 1);
    wr(16'h0d38, 32'h12345678, 4'hf);
    wr(16'h0d8c, 32'h5, 4'hf);
    wr(16'h0d80, 32'ha0, 1);
    settle(8'h80);
    chk("word count", 6, nAck);
    chk("memReq idle", 0, {31'h0, memReq});
    $display("plain scan done");
    wr(16'h0d8c, 32'h7, 4'hf);
    wr(16'h0d80, 32'he0, 1);
    repeat (20) @(posedge clk_sys);
    chk("gated count", 6, nAck);
    scanTrigIn <= 1'b1;
    settle(8'hc0);
    chk("triggered count", 8, nAck);
    $display("trigger scan done");
    scanTrigIn <= 1'b0;
    expRegion = 1'b1;
    wr(16'h0d8c, 32'ha, 4'hf);
    wr(16'h0d80, 32'he6, 1);
    repeat (3) @(posedge clk_sys);
    chk("burst request", 1, {31'h0, memReq});
    settle(8'hc6);
    chk("burst count", 11, nAck);
    rd(16'h0d48);
    chk("scan result", acc, v);
    $display("burst scan done");
    // crc go dropped in mid-scan must stop the scanner
    wr(16'h0d8c, 32'h20, 4'hf);
    wr(16'h0d80, 32'ha4, 1);
    wr(16'h0d58, 32'h80, 1);
    rd(16'h0d80);
    chk("scan ctl after crc stop", 32'h42, {25'h0, v[7:1]});
    chk("memReq after crc stop", 0, {31'h0, memReq});
    $display("crc stop done");
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(16'h0d80);
    chk("scan ctl after reset", 32'h04, v);
    rd(16'h0d48);
    chk("result after reset", 0, v);
    $display("second reset done");
    wrapUp();
  end
endmodule // crs_crc_scanner_test
